// ---- src/tmr_pkg.sv ----
package tmr_pkg;

	// ------------------------------------------------------------
	// register indices on the cpu byte port
	// ------------------------------------------------------------
	localparam int        ADDR_W         = 4;
	localparam bit [3:0]  REG_CTRL_A     = 4'h0;
	localparam bit [3:0]  REG_CTRL_B     = 4'h1;
	localparam bit [3:0]  REG_CNT_LO     = 4'h2;
	localparam bit [3:0]  REG_CNT_HI     = 4'h3;
	localparam bit [3:0]  REG_CMPA_LO    = 4'h4;
	localparam bit [3:0]  REG_CMPA_HI    = 4'h5;
	localparam bit [3:0]  REG_CMPB_LO    = 4'h6;
	localparam bit [3:0]  REG_CMPB_HI    = 4'h7;
	localparam bit [3:0]  REG_CAP_LO     = 4'h8;
	localparam bit [3:0]  REG_CAP_HI     = 4'h9;
	localparam bit [3:0]  REG_IRQ_FLAG   = 4'ha;
	localparam bit [3:0]  REG_IRQ_MASK   = 4'hb;
	localparam bit [3:0]  REG_SYNC_CTRL  = 4'hc;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int        SYNC_HOLD_BIT  = 7;
	localparam int        PSR_ZERO_BIT   = 1;
	localparam int        PSR_ONE_BIT    = 0;
	localparam int        CAP_SRC_BIT    = 5;
	localparam int        CAP_EDGE_BIT   = 6;
	localparam int        CAP_NOISE_BIT  = 7;
	localparam int        FLG_OVF        = 0;
	localparam int        FLG_MATCH_A    = 1;
	localparam int        FLG_MATCH_B    = 2;
	localparam int        FLG_CAP        = 3;
	localparam bit [7:0]  CTRL_B_MASK    = 8'he7;

	// ------------------------------------------------------------
	// reset values and count range
	// ------------------------------------------------------------
	localparam bit [7:0]  BYTE_RESET     = 8'h00;
	localparam bit [15:0] WIDE_RESET     = 16'h0000;
	localparam bit [15:0] CNT_BOTTOM     = 16'h0000;
	localparam bit [15:0] CNT_MAX        = 16'hffff;
	localparam bit [15:0] TOP_8BIT       = 16'h00ff;
	localparam bit [15:0] TOP_9BIT       = 16'h01ff;
	localparam bit [15:0] TOP_10BIT      = 16'h03ff;

	// ------------------------------------------------------------
	// clock select codes, prescaler taps, modes
	// ------------------------------------------------------------
	localparam bit [2:0]  CS_OFF         = 3'h0;
	localparam bit [2:0]  CS_DIV1        = 3'h1;
	localparam bit [2:0]  CS_DIV8        = 3'h2;
	localparam bit [2:0]  CS_DIV64       = 3'h3;
	localparam bit [2:0]  CS_DIV256      = 3'h4;
	localparam bit [2:0]  CS_DIV1024     = 3'h5;
	localparam bit [2:0]  CS_EXT_FALL    = 3'h6;
	localparam bit [2:0]  CS_EXT_RISE    = 3'h7;
	localparam int        PRE_W          = 10;
	localparam bit [9:0]  TAP_8          = 10'h007;
	localparam bit [9:0]  TAP_64         = 10'h03f;
	localparam bit [9:0]  TAP_256        = 10'h0ff;
	localparam bit [9:0]  TAP_1024       = 10'h3ff;
	localparam bit [2:0]  MODE_NORMAL    = 3'h0;
	localparam bit [2:0]  MODE_TOP8      = 3'h1;
	localparam bit [2:0]  MODE_TOP9      = 3'h2;
	localparam bit [2:0]  MODE_TOP10     = 3'h3;
	localparam bit [2:0]  MODE_CTC_A     = 3'h4;
	localparam bit [2:0]  MODE_CTC_CAP   = 3'h5;
	localparam bit [2:0]  MODE_PWM_A     = 3'h6;
	localparam bit [2:0]  MODE_PWM_CAP   = 3'h7;
	localparam int        NOISE_SAMPLES  = 4;

endpackage : tmr_pkg

// ---- src/tmr_timer1_front.sv ----
// Behaviour
// - external edge reaches counter in about three cycles
// - external edges bypass the prescaler
// - hold mode keeps written prescaler reset bits
// - clearing hold mode clears both reset bits
// - timer prescaler reset bit self clears unless holding
// - no clock source selected stops counter
// - compare registers always compared, match sets flag
// - capture event copies counter except in capture-top modes, optional noise filter
// - compare A as PWM top: no PWM output A
// - bottom is 0x0000, max is 0xffff
// - top from fixed values, compare A or capture
// - one shared high byte latch per timer
// - low byte write loads latch and byte together
// - counter or capture low byte read copies high byte into latch
// - compare high byte read bypasses the latch
// - four flags, each gated by a mask bit
// - select 1 undivided, selects 2..5 tap 8..1024
// - select 7 rising, select 6 falling edges
`timescale 1ns/10ps
module tmr_timer1_front (
	// clock and reset
	input  wire logic                       ref_clk,
	input  wire logic                       rstn,
	// cpu byte port
	input  wire logic [tmr_pkg::ADDR_W-1:0] cpu_addr,
	input  wire logic                       cpu_wr_en,
	input  wire logic                       cpu_rd_en,
	input  wire logic [7:0]                 cpu_wdata,
	output logic      [7:0]                 cpu_rdata,
	// pins
	input  wire logic                       ext_count_pin,
	input  wire logic                       capture_pin,
	input  wire logic                       comparator_out,
	// outputs
	output logic                            prescaler_reset_zero,
	output logic      [3:0]                 irq_req,
	output logic                            pwm_out_a,
	output logic                            pwm_out_b
);
	import tmr_pkg::*;

	logic [2:0]       mode_reg;
	logic [7:0]       ctrl_b_reg;
	logic             sync_hold_reg;
	logic             psr_zero_reg;
	logic             psr_one_reg;
	logic [PRE_W-1:0] pre_cnt_reg;
	logic             ext_s1_reg, ext_s2_reg, ext_s3_reg;
	logic [15:0]      cnt_reg;
	logic [7:0]       temp_reg;
	logic [15:0]      cmpa_buf_reg, cmpa_act_reg;
	logic [15:0]      cmpb_buf_reg, cmpb_act_reg;
	logic [15:0]      cap_reg;
	logic             cap_s1_reg, cap_s2_reg;
	logic [NOISE_SAMPLES-1:0] cap_hist_reg;
	logic             cap_filt_reg, cap_prev_reg;
	logic [3:0]       flag_reg;
	logic [3:0]       mask_reg;
	logic [2:0]       clock_select;
	logic             ext_rise, ext_fall, timer_tick;
	logic [15:0]      top_val;
	logic             at_top, pwm_mode, cap_is_top;
	logic             cnt_wr, cap_wr, sync_wr;
	logic             cap_evt, ovf_evt, match_a_evt, match_b_evt;
	logic [3:0]       flag_set, flag_clr;
	logic [7:0]       rd_mux;
	logic [7:0]       cnt_hi_byte, cap_hi_byte, cmpa_hi_byte;

	assign clock_select = ctrl_b_reg[2:0];
	assign cnt_wr       = cpu_wr_en && (cpu_addr == REG_CNT_LO);
	assign cap_wr       = cpu_wr_en && (cpu_addr == REG_CAP_LO);
	assign sync_wr      = cpu_wr_en && (cpu_addr == REG_SYNC_CTRL);
	assign cnt_hi_byte  = cnt_reg[15:8];
	assign cap_hi_byte  = cap_reg[15:8];
	assign cmpa_hi_byte = cmpa_buf_reg[15:8];

	// ------------------------------------------------------------
	// control registers
	// ------------------------------------------------------------
	// mode and clock select, read/write; ctrl A keeps bits 2:0, ctrl B drops bits 4:3
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			mode_reg   <= 3'h0;
			ctrl_b_reg <= BYTE_RESET;
		end else if (cpu_wr_en && cpu_addr == REG_CTRL_A) begin
			mode_reg   <= cpu_wdata[2:0];
		end else if (cpu_wr_en && cpu_addr == REG_CTRL_B) begin
			ctrl_b_reg <= cpu_wdata & CTRL_B_MASK;
		end
	end

	// sync hold and prescaler reset bits; the zero bit only leaves as a port
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			sync_hold_reg <= 1'b0;
			psr_zero_reg  <= 1'b0;
			psr_one_reg   <= 1'b0;
		end else if (sync_wr) begin
			sync_hold_reg <= cpu_wdata[SYNC_HOLD_BIT];
			psr_zero_reg  <= cpu_wdata[PSR_ZERO_BIT];
			psr_one_reg   <= cpu_wdata[PSR_ONE_BIT];
		end else if (!sync_hold_reg) begin
			psr_zero_reg  <= 1'b0;
			psr_one_reg   <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// prescaler and clock select
	// ------------------------------------------------------------
	// free running, so the first tap after enable comes in 1..N cycles
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn)
			pre_cnt_reg <= '0;
		else if (psr_one_reg)
			pre_cnt_reg <= '0;
		else
			pre_cnt_reg <= pre_cnt_reg + 1'b1;
	end

	// two flops synchronise the count pin, the third remembers for edges
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			ext_s1_reg <= 1'b0;
			ext_s2_reg <= 1'b0;
			ext_s3_reg <= 1'b0;
		end else begin
			ext_s1_reg <= ext_count_pin;
			ext_s2_reg <= ext_s1_reg;
			ext_s3_reg <= ext_s2_reg;
		end
	end

	assign ext_rise = ext_s2_reg && !ext_s3_reg;
	assign ext_fall = !ext_s2_reg && ext_s3_reg;

	// tick source; a held prescaler halts every internal source
	always_comb begin
		case (clock_select)
			CS_OFF:      timer_tick = 1'b0;
			CS_DIV1:     timer_tick = !psr_one_reg;
			CS_DIV8:     timer_tick = !psr_one_reg && ((pre_cnt_reg & TAP_8) == TAP_8);
			CS_DIV64:    timer_tick = !psr_one_reg && ((pre_cnt_reg & TAP_64) == TAP_64);
			CS_DIV256:   timer_tick = !psr_one_reg && ((pre_cnt_reg & TAP_256) == TAP_256);
			CS_DIV1024:  timer_tick = !psr_one_reg && (pre_cnt_reg == TAP_1024);
			CS_EXT_FALL: timer_tick = ext_fall;
			CS_EXT_RISE: timer_tick = ext_rise;
			default:     timer_tick = 1'b0;
		endcase
	end

	// ------------------------------------------------------------
	// top selection and counter
	// ------------------------------------------------------------
	always_comb begin
		case (mode_reg)
			MODE_NORMAL:  top_val = CNT_MAX;
			MODE_TOP8:    top_val = TOP_8BIT;
			MODE_TOP9:    top_val = TOP_9BIT;
			MODE_TOP10:   top_val = TOP_10BIT;
			MODE_CTC_A:   top_val = cmpa_act_reg;
			MODE_PWM_A:   top_val = cmpa_act_reg;
			MODE_CTC_CAP: top_val = cap_reg;
			MODE_PWM_CAP: top_val = cap_reg;
			default:      top_val = CNT_MAX;
		endcase
	end

	assign pwm_mode   = (mode_reg == MODE_PWM_A) || (mode_reg == MODE_PWM_CAP);
	assign cap_is_top = (mode_reg == MODE_CTC_CAP) || (mode_reg == MODE_PWM_CAP);
	assign at_top     = (cnt_reg == top_val);
	assign ovf_evt    = timer_tick && at_top && !cnt_wr;

	// a cpu write has priority over counting
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn)
			cnt_reg <= WIDE_RESET;
		else if (cnt_wr)
			cnt_reg <= {temp_reg, cpu_wdata};
		else if (timer_tick && at_top)
			cnt_reg <= CNT_BOTTOM;
		else if (timer_tick)
			cnt_reg <= cnt_reg + 16'h0001;
	end

	// ------------------------------------------------------------
	// shared high byte latch
	// ------------------------------------------------------------
	// one latch for all wide registers; interrupted accesses corrupt it
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn)
			temp_reg <= BYTE_RESET;
		else if (cpu_wr_en && (cpu_addr == REG_CNT_HI || cpu_addr == REG_CMPA_HI ||
				cpu_addr == REG_CMPB_HI || cpu_addr == REG_CAP_HI))
			temp_reg <= cpu_wdata;
		else if (cpu_rd_en && cpu_addr == REG_CNT_LO)
			temp_reg <= cnt_reg[15:8];
		else if (cpu_rd_en && cpu_addr == REG_CAP_LO)
			temp_reg <= cap_reg[15:8];
	end

	// ------------------------------------------------------------
	// compare units
	// ------------------------------------------------------------
	// cpu side buffers, loaded whole on the low byte write
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			cmpa_buf_reg <= WIDE_RESET;
			cmpb_buf_reg <= WIDE_RESET;
		end else if (cpu_wr_en && cpu_addr == REG_CMPA_LO) begin
			cmpa_buf_reg <= {temp_reg, cpu_wdata};
		end else if (cpu_wr_en && cpu_addr == REG_CMPB_LO) begin
			cmpb_buf_reg <= {temp_reg, cpu_wdata};
		end
	end

	// pwm modes update at the wrap so a moving top never glitches
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			cmpa_act_reg <= WIDE_RESET;
			cmpb_act_reg <= WIDE_RESET;
		end else if (!pwm_mode || (timer_tick && at_top)) begin
			cmpa_act_reg <= cmpa_buf_reg;
			cmpb_act_reg <= cmpb_buf_reg;
		end
	end

	assign match_a_evt = timer_tick && (cnt_reg == cmpa_act_reg);
	assign match_b_evt = timer_tick && (cnt_reg == cmpb_act_reg);

	// channel A gives no waveform while it serves as top
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			pwm_out_a <= 1'b0;
			pwm_out_b <= 1'b0;
		end else begin
			pwm_out_a <= (mode_reg == MODE_PWM_CAP) && (cnt_reg < cmpa_act_reg);
			pwm_out_b <= pwm_mode && (cnt_reg < cmpb_act_reg);
		end
	end

	// ------------------------------------------------------------
	// input capture
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			cap_s1_reg <= 1'b0;
			cap_s2_reg <= 1'b0;
		end else begin
			cap_s1_reg <= ctrl_b_reg[CAP_SRC_BIT] ? comparator_out : capture_pin;
			cap_s2_reg <= cap_s1_reg;
		end
	end

	// filter costs NOISE_SAMPLES cycles of latency to reject spikes
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			cap_hist_reg <= '0;
			cap_filt_reg <= 1'b0;
			cap_prev_reg <= 1'b0;
		end else begin
			cap_hist_reg <= {cap_hist_reg[NOISE_SAMPLES-2:0], cap_s2_reg};
			cap_prev_reg <= cap_filt_reg;
			if (!ctrl_b_reg[CAP_NOISE_BIT])
				cap_filt_reg <= cap_s2_reg;
			else if (&cap_hist_reg)
				cap_filt_reg <= 1'b1;
			else if (~|cap_hist_reg)
				cap_filt_reg <= 1'b0;
		end
	end

	assign cap_evt = !cap_is_top && (ctrl_b_reg[CAP_EDGE_BIT] ? (cap_filt_reg && !cap_prev_reg)
	                                                          : (!cap_filt_reg && cap_prev_reg));

	// capture register doubles as a writable top in capture-top modes
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn)
			cap_reg <= WIDE_RESET;
		else if (cap_wr)
			cap_reg <= {temp_reg, cpu_wdata};
		else if (cap_evt)
			cap_reg <= cnt_reg;
	end

	// ------------------------------------------------------------
	// flags and masks
	// ------------------------------------------------------------
	assign flag_set = {cap_evt, match_b_evt, match_a_evt, ovf_evt};

	// write one clears; a set in the same cycle wins
	generate
		for (genvar i = 0; i < 4; i++) begin : g_flag
			assign flag_clr[i] = cpu_wr_en && (cpu_addr == REG_IRQ_FLAG) && cpu_wdata[i];
			always_ff @(posedge ref_clk or negedge rstn) begin
				if (!rstn)
					flag_reg[i] <= 1'b0;
				else
					flag_reg[i] <= flag_set[i] || (flag_reg[i] && !flag_clr[i]);
			end
		end
	endgenerate

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn)
			mask_reg <= 4'h0;
		else if (cpu_wr_en && cpu_addr == REG_IRQ_MASK)
			mask_reg <= cpu_wdata[3:0];
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn)
			irq_req <= 4'h0;
		else
			irq_req <= flag_reg & mask_reg;
	end

	// ------------------------------------------------------------
	// read path and outward reset bit
	// ------------------------------------------------------------
	always_comb begin
		case (cpu_addr)
			REG_CTRL_A:    rd_mux = {5'h00, mode_reg};
			REG_CTRL_B:    rd_mux = ctrl_b_reg;
			REG_CNT_LO:    rd_mux = cnt_reg[7:0];
			REG_CNT_HI:    rd_mux = temp_reg;
			REG_CMPA_LO:   rd_mux = cmpa_buf_reg[7:0];
			REG_CMPA_HI:   rd_mux = cmpa_buf_reg[15:8];
			REG_CMPB_LO:   rd_mux = cmpb_buf_reg[7:0];
			REG_CMPB_HI:   rd_mux = cmpb_buf_reg[15:8];
			REG_CAP_LO:    rd_mux = cap_reg[7:0];
			REG_CAP_HI:    rd_mux = temp_reg;
			REG_IRQ_FLAG:  rd_mux = {4'h0, flag_reg};
			REG_IRQ_MASK:  rd_mux = {4'h0, mask_reg};
			REG_SYNC_CTRL: rd_mux = {sync_hold_reg, 5'h00, psr_zero_reg, psr_one_reg};
			default:       rd_mux = 8'h00;
		endcase
	end

	// read data stands until the next read
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn)
			cpu_rdata <= BYTE_RESET;
		else if (cpu_rd_en)
			cpu_rdata <= rd_mux;
	end

	assign prescaler_reset_zero = psr_zero_reg;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	property p_ext_delay;
		@(posedge ref_clk) disable iff (!rstn)
		(clock_select == CS_EXT_RISE && $rose(ext_s1_reg) && !ext_s2_reg && !cpu_wr_en)
			|=> ##1 (cnt_reg != $past(cnt_reg));
	endproperty
	a_ext_delay: assert property (p_ext_delay) else $error("external edge did not count in time");

	property p_ext_direct;
		@(posedge ref_clk) disable iff (!rstn)
		(clock_select == CS_EXT_RISE && psr_one_reg && ext_rise && !cnt_wr && !at_top)
			|=> (cnt_reg == $past(cnt_reg) + 16'h0001);
	endproperty
	a_ext_direct: assert property (p_ext_direct) else $error("external tick gated by prescaler");

	property p_hold_keeps;
		@(posedge ref_clk) disable iff (!rstn)
		(sync_hold_reg && psr_one_reg && psr_zero_reg && !sync_wr) |=> (psr_one_reg && psr_zero_reg);
	endproperty
	a_hold_keeps: assert property (p_hold_keeps) else $error("held reset bits dropped");

	property p_hold_release;
		@(posedge ref_clk) disable iff (!rstn)
		(sync_wr && !cpu_wdata[SYNC_HOLD_BIT]) ##1 !sync_wr |=> (!psr_one_reg && !psr_zero_reg);
	endproperty
	a_hold_release: assert property (p_hold_release) else $error("reset bits not cleared");

	property p_psr_pulse;
		@(posedge ref_clk) disable iff (!rstn)
		(psr_one_reg && !sync_hold_reg && !sync_wr) |=> (!psr_one_reg && pre_cnt_reg == '0);
	endproperty
	a_psr_pulse: assert property (p_psr_pulse) else $error("prescaler reset misbehaved");

	property p_stopped;
		@(posedge ref_clk) disable iff (!rstn)
		(clock_select == CS_OFF && !cpu_wr_en) [*2] |=> $stable(cnt_reg);
	endproperty
	a_stopped: assert property (p_stopped) else $error("counter moved with no source");

	property p_match_a;
		@(posedge ref_clk) disable iff (!rstn)
		(timer_tick && cnt_reg == cmpa_act_reg) |=> flag_reg[FLG_MATCH_A];
	endproperty
	a_match_a: assert property (p_match_a) else $error("match A flag missing");

	property p_capture;
		@(posedge ref_clk) disable iff (!rstn)
		(cap_evt && !cap_wr) |=> (cap_reg == $past(cnt_reg) && flag_reg[FLG_CAP]);
	endproperty
	a_capture: assert property (p_capture) else $error("capture did not store counter");

	property p_pwm_a_off;
		@(posedge ref_clk) disable iff (!rstn)
		(mode_reg == MODE_PWM_A) |=> !pwm_out_a;
	endproperty
	a_pwm_a_off: assert property (p_pwm_a_off) else $error("pwm A driven while top");

	property p_wrap;
		@(posedge ref_clk) disable iff (!rstn)
		(ovf_evt) |=> (cnt_reg == CNT_BOTTOM && flag_reg[FLG_OVF]);
	endproperty
	a_wrap: assert property (p_wrap) else $error("wrap at top failed");

	property p_wide_write;
		@(posedge ref_clk) disable iff (!rstn)
		cnt_wr |=> (cnt_reg == {$past(temp_reg), $past(cpu_wdata)});
	endproperty
	a_wide_write: assert property (p_wide_write) else $error("wide write wrong");

	property p_low_read;
		@(posedge ref_clk) disable iff (!rstn)
		(cpu_rd_en && cpu_addr == REG_CNT_LO) |=> (temp_reg == $past(cnt_hi_byte));
	endproperty
	a_low_read: assert property (p_low_read) else $error("latch not loaded on low read");

	property p_cmp_read;
		@(posedge ref_clk) disable iff (!rstn)
		(cpu_rd_en && cpu_addr == REG_CMPA_HI && !cpu_wr_en)
			|=> (cpu_rdata == $past(cmpa_hi_byte) && $stable(temp_reg));
	endproperty
	a_cmp_read: assert property (p_cmp_read) else $error("compare high read used latch");

endmodule : tmr_timer1_front

// ---- verification/tmr_cpu_model.sv ----
`timescale 1ns/10ps
module tmr_cpu_model
	import tmr_pkg::*;
(
	// clock
	input  wire logic              ref_clk,
	// byte port towards the timer
	output logic      [ADDR_W-1:0] cpu_addr,
	output logic                   cpu_wr_en,
	output logic                   cpu_rd_en,
	output logic      [7:0]        cpu_wdata
);
	// expected read bytes, oldest first
	logic [7:0] exp_q [$];

	// idle bus at time zero
	initial begin
		cpu_addr  = '0;
		cpu_wr_en = 1'b0;
		cpu_rd_en = 1'b0;
		cpu_wdata = 8'h00;
	end

	// one byte cycle; afterwards address and data show junk so a stale value never passes
	task automatic cyc(input logic [3:0] a, input logic [7:0] d, input logic w);
		@(posedge ref_clk);
		cpu_addr  <= a;
		cpu_wdata <= d;
		cpu_wr_en <= w;
		cpu_rd_en <= ~w;
		@(posedge ref_clk);
		cpu_wr_en <= 1'b0;
		cpu_rd_en <= 1'b0;
		cpu_addr  <= ~a;
		cpu_wdata <= ~d;
	endtask : cyc

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		cyc(a, d, 1'b1);
	endtask : wr

	// note the expectation before the strobe goes out
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		cyc(a, ~e, 1'b0);
	endtask : rd

	// high byte first on writes, low byte first on reads
	task automatic wr16(input logic [3:0] lo, input logic [15:0] v);
		wr(lo + 4'h1, v[15:8]);
		wr(lo, v[7:0]);
	endtask : wr16

	task automatic rd16(input logic [3:0] lo, input logic [15:0] e);
		rd(lo, e[7:0]);
		rd(lo + 4'h1, e[15:8]);
	endtask : rd16
endmodule : tmr_cpu_model

// ---- verification/test_timer1_prescaler_and_wide_access.sv ----
`timescale 1ns/10ps
module test_timer1_prescaler_and_wide_access;
	import tmr_pkg::*;
	logic              ref_clk = 1'b0;
	logic              rstn    = 1'b0;
	logic [ADDR_W-1:0] cpu_addr;
	logic              cpu_wr_en;
	logic              cpu_rd_en;
	logic [7:0]        cpu_wdata;
	logic [7:0]        cpu_rdata;
	logic              ext_count_pin = 1'b0;
	logic              capture_pin   = 1'b0;
	logic              prescaler_reset_zero;
	logic [3:0]        irq_req;
	logic              comparator_out = 1'b0;
	logic              pwm_out_a;
	logic              pwm_out_b;
	logic              rd_d = 1'b0;
	int                num_errors = 0;
	int                cmp_count  = 0;
	int                cyc_count  = 0;
	// wrap table per mode: start value, compare and capture value, flags, pwm pins {a, b}
	logic [2:0]        md [8] = '{MODE_NORMAL, MODE_TOP8, MODE_TOP9, MODE_TOP10, MODE_CTC_A, MODE_CTC_CAP,
		MODE_PWM_A, MODE_PWM_CAP};
	logic [15:0]       st [8] = '{16'hfffd, 16'h00fd, 16'h01fd, 16'h03fd, 16'h000e, 16'h000e, 16'h000e, 16'h000e};
	logic [15:0]       ca [8] = '{16'h8000, 16'h8000, 16'h8000, 16'h8000, 16'h0010, 16'h0010, 16'h0010, 16'h0010};
	logic [7:0]        fl [8] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h03, 8'h03, 8'h03, 8'h03};
	logic [7:0]        pw [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h03};

	// ------------------------------------------------------------
	// clock, parts
	// ------------------------------------------------------------
	initial begin
		forever #20 ref_clk = ~ref_clk;
	end

	tmr_cpu_model tmr_cpu_model_i (.ref_clk(ref_clk), .cpu_addr(cpu_addr), .cpu_wr_en(cpu_wr_en),
		.cpu_rd_en(cpu_rd_en), .cpu_wdata(cpu_wdata));

	// pin capture runs unfiltered, the comparator source goes through the filter
	tmr_timer1_front tmr_timer1_front_i (.ref_clk(ref_clk), .rstn(rstn), .cpu_addr(cpu_addr),
		.cpu_wr_en(cpu_wr_en), .cpu_rd_en(cpu_rd_en), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
		.ext_count_pin(ext_count_pin), .capture_pin(capture_pin), .comparator_out(comparator_out),
		.prescaler_reset_zero(prescaler_reset_zero), .irq_req(irq_req), .pwm_out_a(pwm_out_a),
		.pwm_out_b(pwm_out_b));

	// ------------------------------------------------------------
	// checking and closing
	// ------------------------------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic give_verdict();
		$display("errors %0d, comparisons %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : give_verdict

	// read data lands on the edge that took the read, so look half a cycle later
	always @(posedge ref_clk) rd_d <= cpu_rd_en;
	always @(negedge ref_clk) begin
		if (rd_d === 1'b1)
			chk(cpu_rdata, tmr_cpu_model_i.exp_q.pop_front());
	end

	// the whole run is some six hundred cycles; well above that means a hang
	always @(posedge ref_clk) begin
		cyc_count++;
		if (cyc_count == 8000) begin
			num_errors++;
			give_verdict();
		end
	end

	// external count: each phase three cycles, pin steady around source changes
	task automatic ext_run(input logic [2:0] sel, input int n, input logic fin);
		tmr_cpu_model_i.wr16(REG_CNT_LO, 16'h0000);
		tmr_cpu_model_i.wr(REG_CTRL_B, {5'h0, sel});
		repeat (n) begin
			repeat (3) @(posedge ref_clk);
			ext_count_pin <= 1'b1;
			repeat (3) @(posedge ref_clk);
			ext_count_pin <= 1'b0;
		end
		repeat (3) @(posedge ref_clk);
		ext_count_pin <= fin;
		repeat (4) @(posedge ref_clk);
		tmr_cpu_model_i.wr(REG_CTRL_B, {5'h0, CS_OFF});
	endtask : ext_run

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		logic [15:0] va;
		logic [15:0] vb;
		logic [7:0]  mk;
		int          n;
		void'($urandom(66101));
		repeat (10) @(posedge ref_clk);
		rstn <= 1'b1;
		tmr_cpu_model_i.wr(4'he, 8'hff);
		for (int i = 0; i < 16; i++)
			tmr_cpu_model_i.rd(4'(i), 8'h00);
		va = 16'($urandom());
		vb = 16'($urandom());
		tmr_cpu_model_i.wr16(REG_CMPA_LO, va);
		tmr_cpu_model_i.wr16(REG_CMPB_LO, vb);
		tmr_cpu_model_i.wr(REG_CNT_HI, ~va[15:8]);
		tmr_cpu_model_i.rd(REG_CMPA_HI, va[15:8]);
		tmr_cpu_model_i.wr(REG_CNT_LO, vb[7:0]);
		tmr_cpu_model_i.rd16(REG_CNT_LO, {~va[15:8], vb[7:0]});
		tmr_cpu_model_i.rd16(REG_CMPB_LO, vb);
		tmr_cpu_model_i.rd(REG_CAP_HI, ~va[15:8]);
		// hold both prescaler resets, internal source must stay still
		tmr_cpu_model_i.wr(REG_SYNC_CTRL, 8'h83);
		tmr_cpu_model_i.rd(REG_SYNC_CTRL, 8'h83);
		chk({7'h0, prescaler_reset_zero}, 8'h01);
		tmr_cpu_model_i.wr16(REG_CNT_LO, 16'h0000);
		tmr_cpu_model_i.wr(REG_CTRL_B, {5'h0, CS_DIV1});
		repeat (8) @(posedge ref_clk);
		tmr_cpu_model_i.rd16(REG_CNT_LO, 16'h0000);
		n = 3 + ($urandom() % 4);
		ext_run(CS_EXT_RISE, n, 1'b1);
		tmr_cpu_model_i.rd16(REG_CNT_LO, 16'(n + 1));
		tmr_cpu_model_i.wr(REG_SYNC_CTRL, 8'h00);
		repeat (2) @(posedge ref_clk);
		tmr_cpu_model_i.rd(REG_SYNC_CTRL, 8'h00);
		chk({7'h0, prescaler_reset_zero}, 8'h00);
		tmr_cpu_model_i.wr(REG_SYNC_CTRL, 8'h01);
		repeat (2) @(posedge ref_clk);
		tmr_cpu_model_i.rd(REG_SYNC_CTRL, 8'h00);
		ext_run(CS_EXT_FALL, n, 1'b0);
		tmr_cpu_model_i.rd16(REG_CNT_LO, 16'(n));
		// release a held prescaler: divide by eight restarts from zero, ticks at 8, 16, 24, 32
		tmr_cpu_model_i.wr(REG_SYNC_CTRL, 8'h81);
		tmr_cpu_model_i.wr16(REG_CNT_LO, 16'h0000);
		tmr_cpu_model_i.wr(REG_CTRL_B, {5'h0, CS_DIV8});
		tmr_cpu_model_i.wr(REG_SYNC_CTRL, 8'h00);
		repeat (36) @(posedge ref_clk);
		tmr_cpu_model_i.wr(REG_CTRL_B, {5'h0, CS_OFF});
		tmr_cpu_model_i.rd16(REG_CNT_LO, 16'h0004);
		tmr_cpu_model_i.wr(REG_IRQ_FLAG, 8'h0f);
		// wrap from each top value, with a random mask on the requests
		for (int i = 0; i < 8; i++) begin
			mk = 8'($urandom());
			tmr_cpu_model_i.wr(REG_CTRL_A, {5'h0, md[i]});
			tmr_cpu_model_i.wr16(REG_CMPA_LO, ca[i]);
			tmr_cpu_model_i.wr16(REG_CMPB_LO, 16'h8000);
			tmr_cpu_model_i.wr16(REG_CAP_LO, ca[i]);
			tmr_cpu_model_i.wr16(REG_CNT_LO, st[i]);
			tmr_cpu_model_i.wr(REG_IRQ_MASK, mk);
			tmr_cpu_model_i.rd(REG_IRQ_MASK, {4'h0, mk[3:0]});
			tmr_cpu_model_i.wr(REG_CTRL_B, {5'h0, CS_DIV1});
			repeat (6) @(posedge ref_clk);
			tmr_cpu_model_i.wr(REG_CTRL_B, {5'h0, CS_OFF});
			tmr_cpu_model_i.rd(REG_IRQ_FLAG, fl[i]);
			chk({4'h0, irq_req}, fl[i] & {4'h0, mk[3:0]});
			chk({6'h00, pwm_out_a, pwm_out_b}, pw[i]);
			tmr_cpu_model_i.wr(REG_IRQ_FLAG, 8'h0f);
			tmr_cpu_model_i.rd(REG_IRQ_FLAG, 8'h00);
		end
		// rising capture edge while counting in normal mode
		tmr_cpu_model_i.wr(REG_CTRL_A, {5'h0, MODE_NORMAL});
		tmr_cpu_model_i.wr16(REG_CNT_LO, 16'h0020);
		tmr_cpu_model_i.wr(REG_CTRL_B, 8'h41);
		repeat (4) @(posedge ref_clk);
		capture_pin <= 1'b1;
		repeat (10) @(posedge ref_clk);
		tmr_cpu_model_i.wr(REG_CTRL_B, {5'h0, CS_OFF});
		tmr_cpu_model_i.rd(REG_IRQ_FLAG, 8'h08);
		// comparator through the filter: a two-cycle spike is dropped, a steady rise captured
		tmr_cpu_model_i.wr(REG_IRQ_FLAG, 8'h0f);
		tmr_cpu_model_i.wr(REG_CTRL_B, 8'he1);
		repeat (10) @(posedge ref_clk);
		comparator_out <= 1'b1;
		repeat (2) @(posedge ref_clk);
		comparator_out <= 1'b0;
		repeat (8) @(posedge ref_clk);
		tmr_cpu_model_i.rd(REG_IRQ_FLAG, 8'h00);
		comparator_out <= 1'b1;
		repeat (12) @(posedge ref_clk);
		tmr_cpu_model_i.wr(REG_CTRL_B, {5'h0, CS_OFF});
		tmr_cpu_model_i.rd(REG_IRQ_FLAG, 8'h08);
		repeat (4) @(posedge ref_clk);
		give_verdict();
	end
endmodule : test_timer1_prescaler_and_wide_access
